// ==== ind_b_ctrl.sv ====
// second status indicator controller: blink timing, source select, link gating
// assumes register strobes and all status inputs are synchronous to CLK_IN
`timescale 1ns/1ps
`include "ind_b_defines.svh"
module ind_b_ctrl
  import ind_b_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS,
  parameter int WINDOW_TICKS = `WINDOW_MIN_MS / `TICK_MS
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [15:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  input wire traffic_t TRAFFIC_IN,
  input wire status_t STATUS_IN,
  input wire clk_taps_t CLK_TAPS_IN,
  output logic INDICATOR_B_PIN_OUT
);

  logic [15:0] blink_times;
  logic [15:0] ctrl;
  logic [31:0] tick_cnt;
  logic [15:0] win_cnt;
  logic [15:0] busy_ticks;
  logic busy_in_tick;
  logic [3:0] level;
  logic act_seen;

  // register access
  wire wr_times = REG_WR_IN && (REG_ADDR_IN == `BLINK_TIMES_ADDR);
  wire wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `CTRL_ADDR);
  wire [15:0] read_mux = (REG_ADDR_IN == `BLINK_TIMES_ADDR) ? blink_times :
                         (REG_ADDR_IN == `CTRL_ADDR) ? ctrl : 16'h0000;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      blink_times <= `BLINK_TIMES_RESET;
      ctrl <= `CTRL_RESET;
      REG_RDATA_OUT <= 16'h0000;
    end else begin
      if (wr_times) begin
        blink_times <= REG_WDATA_IN;
      end
      if (wr_ctrl) begin
        ctrl <= REG_WDATA_IN;
      end
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= read_mux;
      end
    end
  end

  wire [7:0] ind_b_on_time_count = blink_times[`ON_MSB:`ON_LSB];
  wire [7:0] ind_b_off_time_count = blink_times[`OFF_MSB:`OFF_LSB];
  wire ind_b_output_enable = ctrl[`EN_BIT];
  wire ind_b_gate_with_link = ctrl[`QUAL_BIT];
  wire ind_b_blink_style = ctrl[`STYLE_BIT];
  wire [4:0] ind_b_source_select = ctrl[`SRC_MSB:`SRC_LSB];
  wire [4:0] src = ind_b_source_select;

  // 4 ms time base
  wire tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // source decode
  wire link = TRAFFIC_IN.link_up;
  wire link_combo = (src == SRC_LINK_ANY_TRAFFIC) || (src == SRC_LINK_TRANSMIT_TRAFFIC) ||
                    (src == SRC_LINK_RECEIVE_TRAFFIC) || (src == SRC_LINK_RECEIVE_FAULT) ||
                    (src == SRC_LINK_ANY_FAULT);
  wire pure_traffic = (src == SRC_TRANSMIT_TRAFFIC) || (src == SRC_RECEIVE_TRAFFIC) ||
                      (src == SRC_RECEIVE_FAULT) || (src == SRC_TRANSMIT_FRAME_BEGIN) ||
                      (src == SRC_RECEIVE_FRAME_BEGIN);
  wire traffic_src = link_combo || pure_traffic;
  wire act_now =
    (src == SRC_LINK_ANY_TRAFFIC) ? (TRAFFIC_IN.tx_act | TRAFFIC_IN.rx_act) :
    (src == SRC_LINK_TRANSMIT_TRAFFIC) ? TRAFFIC_IN.tx_act :
    (src == SRC_LINK_RECEIVE_TRAFFIC) ? TRAFFIC_IN.rx_act :
    (src == SRC_TRANSMIT_TRAFFIC) ? TRAFFIC_IN.tx_act :
    (src == SRC_RECEIVE_TRAFFIC) ? TRAFFIC_IN.rx_act :
    (src == SRC_LINK_RECEIVE_FAULT) ? TRAFFIC_IN.rx_err :
    (src == SRC_LINK_ANY_FAULT) ? (TRAFFIC_IN.rx_err | TRAFFIC_IN.tx_err) :
    (src == SRC_RECEIVE_FAULT) ? TRAFFIC_IN.rx_err :
    (src == SRC_TRANSMIT_FRAME_BEGIN) ? TRAFFIC_IN.src_transmit_frame_begin :
    (src == SRC_RECEIVE_FRAME_BEGIN) ? TRAFFIC_IN.src_receive_frame_begin : 1'b0;

  // swing-level and role sources take the optional link gate; the rest never do
  wire gate_ok = !ind_b_gate_with_link || link;
  wire status_val =
    (src == STAT_HIGH_SWING_LEVEL) ? (STATUS_IN.high_swing & gate_ok) :
    (src == STAT_LOW_SWING_LEVEL) ? (STATUS_IN.low_swing & gate_ok) :
    (src == STAT_ROLE_LEADER) ? (STATUS_IN.role_leader & gate_ok) :
    (src == STAT_ROLE_FOLLOWER) ? (STATUS_IN.role_follower & gate_ok) :
    (src == STAT_LINK_CONFIG_MISMATCH) ? STATUS_IN.link_config_mismatch :
    (src == STAT_NEGOTIATED_LINK_OK) ? STATUS_IN.negotiated_link_ok :
    (src == STAT_NEGOTIATION_DONE) ? STATUS_IN.negotiation_done :
    (src == STAT_TEST_TIMER) ? STATUS_IN.test_timer :
    (src == STAT_LOCAL_RECEIVER_OK) ? STATUS_IN.local_receiver_ok :
    (src == STAT_REMOTE_RECEIVER_OK) ? STATUS_IN.remote_receiver_ok : 1'b0;
  wire status_src = (src >= STAT_HIGH_SWING_LEVEL) && (src <= STAT_REMOTE_RECEIVER_OK);
  wire clock_src = (src >= OUT_REFERENCE_CLOCK) && (src <= OUT_INTERNAL_FAST_CLOCK);
  wire clock_val = (src == OUT_REFERENCE_CLOCK) ? CLK_TAPS_IN.reference :
                   (src == OUT_TRANSMIT_CLOCK) ? CLK_TAPS_IN.transmit : CLK_TAPS_IN.internal_fast;

  // activity grading over a window of 4 ms ticks
  wire win_end = tick && (win_cnt == 16'(WINDOW_TICKS - 1));
  // the closing tick counts too, else a fully busy window could never reach level 10
  wire [15:0] busy_total = busy_ticks + 16'(busy_in_tick || act_now);
  logic [3:0] next_level;
  always_comb begin
    next_level = 4'h0;
    for (int k = 1; k <= `GRADE_STEPS; k++) begin
      if (32'(busy_total) * `GRADE_STEPS >= 32'(k * WINDOW_TICKS)) begin
        next_level = 4'(k);
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      win_cnt <= '0;
      busy_ticks <= '0;
      busy_in_tick <= 1'b0;
      level <= 4'h0;
    end else begin
      busy_in_tick <= act_now || (busy_in_tick && !tick);
      if (tick) begin
        win_cnt <= win_end ? '0 : win_cnt + 1'b1;
        busy_ticks <= win_end ? '0 : busy_ticks + 16'(busy_in_tick || act_now);
      end
      if (win_end) begin
        level <= next_level;
      end
    end
  end

  // style 1 scales the lengths by tenths: x / 10 taken as x * 205 >> 11
  wire [11:0] on_prod = 12'(ind_b_on_time_count * (4'd10 - level));
  wire [12:0] off_prod = 13'(ind_b_off_time_count * (5'd10 + 5'(level)));
  wire [22:0] on_div = 23'(on_prod) * 23'd205;
  wire [23:0] off_div = 24'(off_prod) * 24'd205;
  wire [8:0] off_scaled = off_div[19:11];
  wire [7:0] on_len = ind_b_blink_style ? on_div[18:11] : ind_b_on_time_count;
  wire [7:0] off_len = !ind_b_blink_style ? ind_b_off_time_count :
                       off_scaled[8] ? 8'hff : off_scaled[7:0];

  // short traffic pulses hold the blink going until the current cycle completes
  logic cycle_done;
  logic phase_on;
  wire times_zero = (ind_b_on_time_count == 8'h00) && (ind_b_off_time_count == 8'h00);
  wire traffic_blink = traffic_src && !times_zero && (act_now || act_seen) && (!link_combo || link);
  wire blink_run = ind_b_output_enable && ((src == SRC_BLINK) || traffic_blink);

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      act_seen <= 1'b0;
    end else begin
      act_seen <= act_now || (act_seen && !cycle_done && blink_run);
    end
  end

  ind_b_phaser #(.LEN_W(8)) u_phaser (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .tick_in(tick),
    .run_in(blink_run),
    .start_on_in(ind_b_blink_style),
    .on_len_in(on_len),
    .off_len_in(off_len),
    .phase_on_out(phase_on),
    .cycle_done_out(cycle_done)
  );

  // idle level of a traffic source when no blink runs
  wire traffic_idle = times_zero ? (link_combo ? (link && !act_now) : act_now) :
                      (link_combo ? link : 1'b0);
  wire next_pin = !ind_b_output_enable ? 1'b0 :
                  clock_src ? clock_val :
                  status_src ? status_val :
                  (src == SRC_ON) ? 1'b1 :
                  blink_run ? phase_on :
                  traffic_src ? traffic_idle : 1'b0;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      INDICATOR_B_PIN_OUT <= 1'b0;
    end else begin
      INDICATOR_B_PIN_OUT <= next_pin;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_enabled_src(logic [4:0] code);
    ind_b_output_enable && src == code;
  endsequence

  a_disabled_dark: assert property (!ind_b_output_enable |=> !INDICATOR_B_PIN_OUT)
    else $error("disabled indicator was lit");
  a_forced_on_lit: assert property (s_enabled_src(SRC_ON) |=> INDICATOR_B_PIN_OUT)
    else $error("forced-on source left indicator dark");
  a_clock_bypass: assert property (s_enabled_src(OUT_REFERENCE_CLOCK)
                                   |=> INDICATOR_B_PIN_OUT == $past(CLK_TAPS_IN.reference))
    else $error("reference clock not passed to the pin");
  a_status_static: assert property (s_enabled_src(STAT_NEGOTIATED_LINK_OK)
                                    |=> INDICATOR_B_PIN_OUT == $past(STATUS_IN.negotiated_link_ok))
    else $error("status source did not show statically");
  a_gate_link_down: assert property ((s_enabled_src(STAT_HIGH_SWING_LEVEL) and (ind_b_gate_with_link && !link))
                                     |=> !INDICATOR_B_PIN_OUT)
    else $error("gated swing source lit without link");
  a_never_gated: assert property ((s_enabled_src(STAT_NEGOTIATION_DONE) and (ind_b_gate_with_link && !link))
                                  |=> INDICATOR_B_PIN_OUT == $past(STATUS_IN.negotiation_done))
    else $error("ungated source was gated by link");
  a_live_monitor: assert property ((s_enabled_src(SRC_TRANSMIT_TRAFFIC) and times_zero)
                                   |=> INDICATOR_B_PIN_OUT == $past(TRAFFIC_IN.tx_act))
    else $error("zero lengths did not show traffic live");
  a_link_idle_lit: assert property ((s_enabled_src(SRC_LINK_TRANSMIT_TRAFFIC) and (!times_zero && !blink_run))
                                    |=> INDICATOR_B_PIN_OUT == $past(link))
    else $error("link source idle level wrong");
  a_level_hold: assert property (!win_end |=> $stable(level))
    else $error("traffic level changed inside a window");
  a_times_readback: assert property (REG_RD_IN && REG_ADDR_IN == `BLINK_TIMES_ADDR && !wr_times
                                     |=> REG_RDATA_OUT == $past(blink_times))
    else $error("blink time register read back wrong");

endmodule

// ==== ind_b_defines.svh ====
// offsets, field positions, reset values and timing counts for the second indicator
// assumes a 100 MHz core clock and 16-bit management register access
`ifndef IND_B_DEFINES_SVH
`define IND_B_DEFINES_SVH

`define BLINK_TIMES_ADDR 16'h8c81
`define CTRL_ADDR 16'h8c82
`define BLINK_TIMES_RESET 16'h3636
`define CTRL_RESET 16'h8480

`define ON_MSB 15
`define ON_LSB 8
`define OFF_MSB 7
`define OFF_LSB 0
`define EN_BIT 15
`define QUAL_BIT 14
`define STYLE_BIT 13
`define SRC_MSB 12
`define SRC_LSB 8

`define CLK_PERIOD_NS 10
`define TICK_MS 4
`define TICK_NS (`TICK_MS * 1000000)
`define WINDOW_MIN_MS 640
`define WINDOW_MAX_MS 1500
`define GRADE_STEPS 10

`endif

// ==== ind_b_pkg.sv ====
// types shared by the indicator controller and its phase timer
// assumes nothing beyond the defines header
package ind_b_pkg;

  typedef enum logic [4:0] {
    SRC_LINK_ANY_TRAFFIC = 5'h00,
    SRC_LINK_TRANSMIT_TRAFFIC = 5'h01,
    SRC_LINK_RECEIVE_TRAFFIC = 5'h02,
    SRC_TRANSMIT_TRAFFIC = 5'h05,
    SRC_RECEIVE_TRAFFIC = 5'h06,
    SRC_LINK_RECEIVE_FAULT = 5'h07,
    SRC_LINK_ANY_FAULT = 5'h08,
    SRC_RECEIVE_FAULT = 5'h09,
    SRC_TRANSMIT_FRAME_BEGIN = 5'h0b,
    SRC_RECEIVE_FRAME_BEGIN = 5'h0c,
    SRC_ON = 5'h0d,
    SRC_OFF = 5'h0e,
    SRC_BLINK = 5'h0f,
    STAT_HIGH_SWING_LEVEL = 5'h10,
    STAT_LOW_SWING_LEVEL = 5'h11,
    STAT_ROLE_LEADER = 5'h12,
    STAT_ROLE_FOLLOWER = 5'h13,
    STAT_LINK_CONFIG_MISMATCH = 5'h14,
    STAT_NEGOTIATED_LINK_OK = 5'h15,
    STAT_NEGOTIATION_DONE = 5'h16,
    STAT_TEST_TIMER = 5'h17,
    STAT_LOCAL_RECEIVER_OK = 5'h18,
    STAT_REMOTE_RECEIVER_OK = 5'h19,
    OUT_REFERENCE_CLOCK = 5'h1a,
    OUT_TRANSMIT_CLOCK = 5'h1b,
    OUT_INTERNAL_FAST_CLOCK = 5'h1c
  } ind_src_t;

  typedef struct packed {
    logic link_up;
    logic tx_act;
    logic rx_act;
    logic tx_err;
    logic rx_err;
    logic src_transmit_frame_begin;
    logic src_receive_frame_begin;
  } traffic_t;

  typedef struct packed {
    logic high_swing;
    logic low_swing;
    logic role_leader;
    logic role_follower;
    logic link_config_mismatch;
    logic negotiated_link_ok;
    logic negotiation_done;
    logic test_timer;
    logic local_receiver_ok;
    logic remote_receiver_ok;
  } status_t;

  typedef struct packed {
    logic reference;
    logic transmit;
    logic internal_fast;
  } clk_taps_t;

  typedef enum {PH_IDLE, PH_OFF, PH_ON} phase_state_t;

endpackage

// ==== ind_b_phaser.sv ====
// on/off phase timer for the indicator blink, counted in 4 ms ticks
// assumes tick is a one-cycle pulse and the lengths are held stable by the caller
`timescale 1ns/1ps
`include "ind_b_defines.svh"
module ind_b_phaser
  import ind_b_pkg::*;
#(
  parameter int LEN_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic start_on_in,
  input wire logic [LEN_W-1:0] on_len_in,
  input wire logic [LEN_W-1:0] off_len_in,
  output logic phase_on_out,
  output logic cycle_done_out
);

  phase_state_t state;
  logic [LEN_W-1:0] remain;
  // a phase ends on the tick that spends its last unit, so a steady phase of length 1 or more lasts exactly its length
  wire phase_end = tick_in && (remain[LEN_W-1:1] == '0);
  wire leaving_on = phase_end && (state == PH_ON);
  wire leaving_off = phase_end && (state == PH_OFF);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= PH_IDLE;
      remain <= '0;
    end else if (!run_in) begin
      state <= PH_IDLE;
      remain <= '0;
    end else begin
      case (state)
        PH_IDLE: begin
          state <= start_on_in ? PH_ON : PH_OFF;
          remain <= start_on_in ? on_len_in : off_len_in;
        end
        PH_OFF: begin
          if (phase_end) begin
            state <= PH_ON;
            remain <= on_len_in;
          end else if (tick_in) begin
            remain <= remain - 1'b1;
          end
        end
        PH_ON: begin
          if (phase_end) begin
            state <= PH_OFF;
            remain <= off_len_in;
          end else if (tick_in) begin
            remain <= remain - 1'b1;
          end
        end
        default: state <= PH_IDLE;
      endcase
    end
  end

  assign phase_on_out = (state == PH_ON);
  // a cycle ends when the second of its two phases runs out
  assign cycle_done_out = run_in && (start_on_in ? leaving_off : leaving_on);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_start;
    run_in && state == PH_IDLE;
  endsequence

  a_first_phase_on: assert property ((s_start and start_on_in) |=> phase_on_out)
    else $error("blink did not start in the on phase");
  a_first_phase_off: assert property ((s_start and !start_on_in) |=> state == PH_OFF)
    else $error("blink did not start in the off phase");
  a_phase_tick_only: assert property (run_in && !tick_in && state != PH_IDLE |=> $stable(state))
    else $error("blink phase changed without a tick");

endmodule

// ==== ind_b_led_model.sv ====
// behavioural indicator lamp hanging on the second indicator pin
// assumes the pin is a plain push-pull drive, high = lit, sampled on the core clock
`timescale 1ns/1ps
module ind_b_led_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic drive_in,
  output logic [15:0] flash_count_out,
  output logic lit_out
);
  logic was_lit;

  // a lamp only sees the level; it counts each dark-to-lit change as one flash
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      was_lit <= 1'b0;
      flash_count_out <= 16'h0000;
    end else begin
      was_lit <= drive_in;
      if (drive_in && !was_lit) begin
        flash_count_out <= flash_count_out + 16'h0001;
      end
    end
  end

  assign lit_out = drive_in;
endmodule

// ==== led_indicator_blink_ctrl_tb.sv ====
// self-checking bench for the second indicator controller
// assumes a shortened tick of 10 cycles and a 20-tick grading window
`timescale 1ns/1ps
`include "ind_b_defines.svh"
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s: expected %h, seen %h", name, exp, got); end end
module led_indicator_blink_ctrl_tb;
  import ind_b_pkg::*;
  localparam int TICK = 10;
  logic CLK_IN, RESET_N_IN, REG_WR_IN, REG_RD_IN, INDICATOR_B_PIN_OUT, lit;
  logic [15:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, flashes, f0;
  traffic_t TRAFFIC_IN;
  status_t STATUS_IN;
  clk_taps_t CLK_TAPS_IN;
  int errors, check_count, dur;
  int pure_code[5] = '{5, 6, 9, 11, 12};
  int pure_bit[5] = '{5, 4, 2, 1, 0};
  int link_code[5] = '{0, 1, 2, 7, 8};
  int link_bit[5] = '{4, 5, 4, 2, 3};

  ind_b_ctrl #(.TICK_CYCLES(TICK), .WINDOW_TICKS(20)) dut (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .TRAFFIC_IN(TRAFFIC_IN), .STATUS_IN(STATUS_IN),
    .CLK_TAPS_IN(CLK_TAPS_IN), .INDICATOR_B_PIN_OUT(INDICATOR_B_PIN_OUT));
  ind_b_led_model lamp (.clk_in(CLK_IN), .reset_n_in(RESET_N_IN), .drive_in(INDICATOR_B_PIN_OUT),
    .flash_count_out(flashes), .lit_out(lit));

  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end

  function automatic logic [15:0] ctl(input logic en, input logic gate, input logic style, input int src);
    return {en, gate, style, 5'(src), 8'h00};
  endfunction

  // a phase of L ticks is seen somewhere between L-1 and L+1 whole ticks from mid-phase
  function automatic logic in_range(input int cycles, input int len);
    return (cycles >= (len - 1) * TICK) && (cycles <= (len + 1) * TICK);
  endfunction

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b1;
    REG_ADDR_IN <= addr;
    REG_WDATA_IN <= data;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b1;
    REG_ADDR_IN <= addr;
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
    #1;
    `CHK("read data", exp, REG_RDATA_OUT)
  endtask

  // settings take a cycle to land and the pin one more
  task automatic pin_is(input logic exp);
    repeat (3) @(posedge CLK_IN);
    #1;
    `CHK("indicator pin", exp, INDICATOR_B_PIN_OUT)
    // return on an edge so that the next stimulus is applied on it
    @(posedge CLK_IN);
  endtask

  // counts the cycles for which the pin stays at lvl
  task automatic hold_len(input logic lvl);
    dur = 0;
    while (INDICATOR_B_PIN_OUT === lvl && dur < 200) begin
      @(posedge CLK_IN);
      #1;
      dur++;
    end
  endtask

  task automatic blink_check(input logic [15:0] cw, input logic first);
    f0 = flashes;
    wr(`CTRL_ADDR, cw);
    repeat (2) @(posedge CLK_IN);
    #1;
    `CHK("first blink phase", first, INDICATOR_B_PIN_OUT)
    `CHK("lamp state", first, lit)
    hold_len(first);
    `CHK("first phase length", 1'b1, in_range(dur, first ? 5 : 4))
    // the second phase starts on a tick, so it lasts exactly its programmed length
    hold_len(!first);
    `CHK("second phase length", (first ? 4 : 5) * TICK, dur)
    `CHK("lamp flashed", 1'b1, flashes > f0)
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK_IN);
    errors++;
    results();
  end

  initial begin
    errors = 0;
    check_count = 0;
    RESET_N_IN = 1'b0;
    REG_WR_IN = 1'b0;
    REG_RD_IN = 1'b0;
    REG_ADDR_IN = 16'h0000;
    REG_WDATA_IN = 16'h0000;
    TRAFFIC_IN = '0;
    STATUS_IN = '0;
    CLK_TAPS_IN = '0;
    repeat (2) @(posedge CLK_IN);
    RESET_N_IN <= 1'b1;
    rd(`BLINK_TIMES_ADDR, 16'h3636);
    rd(`CTRL_ADDR, 16'h8480);
    rd(16'h8c83, 16'h0000);
    pin_is(1'b0);
    wr(16'h8c83, 16'hffff);
    rd(`CTRL_ADDR, 16'h8480);
    // lengths above 3 as software is advised
    wr(`BLINK_TIMES_ADDR, 16'h0504);
    rd(`BLINK_TIMES_ADDR, 16'h0504);
    wr(`CTRL_ADDR, ctl(1, 0, 0, 13));
    pin_is(1'b1);
    wr(`CTRL_ADDR, ctl(0, 0, 0, 13));
    pin_is(1'b0);
    wr(`CTRL_ADDR, ctl(1, 0, 0, 14));
    pin_is(1'b0);
    blink_check(ctl(1, 0, 0, 15), 1'b0);
    // stop the blink so that the style 1 run starts from idle
    wr(`CTRL_ADDR, ctl(1, 0, 0, 14));
    blink_check(ctl(1, 0, 1, 15), 1'b1);
    // traffic sources with timing: idle levels, then held traffic blinks
    wr(`CTRL_ADDR, ctl(1, 0, 0, 5));
    pin_is(1'b0);
    TRAFFIC_IN <= 7'h40;
    wr(`CTRL_ADDR, ctl(1, 0, 0, 1));
    pin_is(1'b1);
    TRAFFIC_IN <= 7'h20;
    wr(`CTRL_ADDR, ctl(1, 0, 0, 14));
    blink_check(ctl(1, 0, 0, 5), 1'b0);
    // style 1 under constant traffic: after two windows the level is 10,
    // the on phase shrinks to one tick and the off phase doubles
    wr(`CTRL_ADDR, ctl(1, 0, 1, 5));
    repeat (45 * TICK) @(posedge CLK_IN);
    #1;
    hold_len(1'b0);
    hold_len(1'b1);
    `CHK("graded on length", 1'b1, dur <= TICK)
    hold_len(1'b0);
    `CHK("graded off length", 8 * TICK, dur)
    // zero lengths: the selected signal is shown live; all codes in style 0 only
    wr(`BLINK_TIMES_ADDR, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      TRAFFIC_IN <= 7'h00;
      wr(`CTRL_ADDR, ctl(1, 0, 0, pure_code[i]));
      pin_is(1'b0);
      TRAFFIC_IN <= traffic_t'(7'h40 | (7'h01 << pure_bit[i]));
      pin_is(1'b1);
      TRAFFIC_IN <= 7'h40;
      wr(`CTRL_ADDR, ctl(1, 0, 0, link_code[i]));
      pin_is(1'b1);
      TRAFFIC_IN <= traffic_t'(7'h40 | (7'h01 << link_bit[i]));
      pin_is(1'b0);
      TRAFFIC_IN <= 7'h00;
      pin_is(1'b0);
    end
    // status sources with link down: only level and role codes obey the gate
    wr(`BLINK_TIMES_ADDR, 16'h0504);
    for (int g = 0; g < 2; g++) begin
      for (int c = 16; c < 26; c++) begin
        STATUS_IN <= '0;
        wr(`CTRL_ADDR, ctl(1, g[0], 0, c));
        pin_is(1'b0);
        STATUS_IN <= status_t'(10'h001 << (25 - c));
        pin_is(!(g == 1 && c < 20));
      end
    end
    // a gated level source passes once the link is up
    TRAFFIC_IN <= 7'h40;
    STATUS_IN <= 10'h200;
    wr(`CTRL_ADDR, ctl(1, 1, 0, 16));
    pin_is(1'b1);
    STATUS_IN <= '0;
    for (int i = 0; i < 3; i++) begin
      wr(`CTRL_ADDR, ctl(1, 1, 0, 26 + i));
      CLK_TAPS_IN <= clk_taps_t'(3'h4 >> i);
      pin_is(1'b1);
      CLK_TAPS_IN <= '0;
      pin_is(1'b0);
    end
    results();
  end
endmodule
